// ==== hw/tdil_cfg.svh ====
// Constants for the loopback status and drop and insert block.
`ifndef TDIL_CFG_SVH
`define TDIL_CFG_SVH

// ----------------------------------------------------------------
// Register indices (byte address is four times the index)
// ----------------------------------------------------------------
`define TDIL_IDX_LB_STATUS_LOW   10'h05c
`define TDIL_IDX_LB_STATUS_HIGH  10'h05e
`define TDIL_IDX_DROP_SELECT     10'h060
`define TDIL_IDX_INSERT_SELECT   10'h062
`define TDIL_IDX_IRQ_STATUS      10'h064
`define TDIL_IDX_IRQ_MASK        10'h066

// ----------------------------------------------------------------
// Field positions
// ----------------------------------------------------------------
`define TDIL_SEL_A_LSB           0
`define TDIL_SEL_B_LSB           8
`define TDIL_SEL_W               5
`define TDIL_LB_LOW_PORTS        16
`define TDIL_LB_HIGH_PORTS       12
`define TDIL_LB_IRQ_BIT          0

// ----------------------------------------------------------------
// Reset values and counts
// ----------------------------------------------------------------
`define TDIL_DROP_SELECT_RST     16'h0000
`define TDIL_INSERT_SELECT_RST   16'h0000
`define TDIL_IRQ_MASK_RST        1'h0
`define TDIL_PORT_COUNT          28
`define TDIL_PERSIST_FRAMES      3'h5

`endif

// ==== hw/tdil_lb_detect.sv ====
// Persistence filter for one port's far-end loopback command.
`include "tdil_cfg.svh"

module tdil_lb_detect
   import tdil_pkg::*;
(
   input  wire logic clk_i,
   input  wire logic rst_i,
   input  wire logic frame_i,
   input  wire logic cmd_now_i,
   output logic      seen_o,
   output logic      rise_o
);

   tdil_frame_cnt_type cnt_reg;
   logic               seen_reg;
   logic               rise_reg;

   // ----------------------------------------------------------------
   // Frame counter and status
   // ----------------------------------------------------------------
   // The counter holds the run of frames that disagree with the status.
   always_ff @(posedge clk_i) begin
      if (rst_i) begin
         cnt_reg  <= 3'h0;
         seen_reg <= 1'b0;
      end else if (frame_i) begin
         if (cmd_now_i == seen_reg) begin
            cnt_reg <= 3'h0;
         end else if (cnt_reg == `TDIL_PERSIST_FRAMES - 3'h1) begin
            seen_reg <= cmd_now_i;
            cnt_reg  <= 3'h0;
         end else begin
            cnt_reg <= cnt_reg + 3'h1;
         end
      end
   end

   always_ff @(posedge clk_i) begin
      if (rst_i) begin
         rise_reg <= 1'b0;
      end else begin
         rise_reg <= frame_i && cmd_now_i && !seen_reg
                     && cnt_reg == `TDIL_PERSIST_FRAMES - 3'h1;
      end
   end

   assign seen_o = seen_reg;
   assign rise_o = rise_reg;

endmodule : tdil_lb_detect

// ==== hw/tdil_pkg.sv ====
// Types shared by the loopback status and drop and insert block.
`include "tdil_cfg.svh"

package tdil_pkg;

   typedef logic [`TDIL_PORT_COUNT-1:0] tdil_port_vec_type;
   typedef logic [`TDIL_SEL_W-1:0]      tdil_sel_type;
   typedef logic [2:0]                  tdil_frame_cnt_type;

endpackage : tdil_pkg

// ==== hw/tdil_port_sel.sv ====
// Decoder of one 5-bit port selector into a one-hot port vector.
`include "tdil_cfg.svh"

module tdil_port_sel
   import tdil_pkg::*;
(
   input  wire tdil_pkg::tdil_sel_type     sel_i,
   output tdil_pkg::tdil_port_vec_type       hit_o
);

   // ----------------------------------------------------------------
   // Decode
   // ----------------------------------------------------------------
   // Zero and codes above the last port match no bit, so they select nothing.
   genvar g;
   generate
      for (g = 0; g < `TDIL_PORT_COUNT; g = g + 1) begin : g_dec
         assign hit_o[g] = (sel_i == 5'(g + 1));
      end
   endgenerate

endmodule : tdil_port_sel

// ==== hw/tdil_top.sv ====
// Loopback command status, drop port select and insert port select.
// What this block does
// - Five inverted-C3 frames set port status.
// - Five normal-C3 frames clear port status.
// - Ports 1-16 low register, 17-28 high.
// - Status bits read-only, live, ignore writes.
// - Status set with mask raises interrupt.
// - Drop select: A bits 0-4, B 8-12.
// - Codes 1..28 select ports, others none.
// - No drop port: clock and data low.
// - Insert select same layout and coding.
// - Insert port replaces named transmit port.
// - Unselected insert port inputs are ignored.
`include "tdil_cfg.svh"

module tdil_top
   import tdil_pkg::*;
(
   input  wire logic                     clk_i,
   input  wire logic                     rst_i,
   // Wishbone slave.
   input  wire logic                     wb_cyc_i,
   input  wire logic                     wb_stb_i,
   input  wire logic                     wb_we_i,
   input  wire logic [11:0]              wb_adr_i,
   input  wire logic [3:0]               wb_sel_i,
   input  wire logic [31:0]              wb_dat_i,
   output logic      [31:0]              wb_dat_o,
   output logic                          wb_ack_o,
   output logic                          irq_o,
   // T2 framer C-bit observations, one per low-speed port.
   input  wire tdil_pkg::tdil_port_vec_type t2_frame_i,
   input  wire tdil_pkg::tdil_port_vec_type t2_c1_i,
   input  wire tdil_pkg::tdil_port_vec_type t2_c2_i,
   input  wire tdil_pkg::tdil_port_vec_type t2_c3_i,
   // Low-speed receive ports from the demultiplexer.
   input  wire tdil_pkg::tdil_port_vec_type lsp_rx_clk_i,
   input  wire tdil_pkg::tdil_port_vec_type lsp_rx_data_i,
   // Low-speed transmit ports toward the multiplexer.
   input  wire tdil_pkg::tdil_port_vec_type lsp_tx_clk_i,
   input  wire tdil_pkg::tdil_port_vec_type lsp_tx_data_i,
   output tdil_pkg::tdil_port_vec_type      lsp_tx_clk_o,
   output tdil_pkg::tdil_port_vec_type      lsp_tx_data_o,
   // Drop port pins.
   output logic                          drop_a_clock_out_o,
   output logic                          drop_a_data_out_o,
   output logic                          drop_b_clock_out_o,
   output logic                          drop_b_data_out_o,
   // Insert port pins.
   input  wire logic                     insert_a_clock_in_i,
   input  wire logic                     insert_a_data_in_i,
   input  wire logic                     insert_b_clock_in_i,
   input  wire logic                     insert_b_data_in_i
);

   // ----------------------------------------------------------------
   // Declarations
   // ----------------------------------------------------------------
   logic [15:0]       drop_select_reg;
   logic [15:0]       insert_select_reg;
   logic              irq_status_reg;
   logic              irq_mask_reg;
   logic              irq_reg;
   logic              ack_reg;
   logic [31:0]       dat_reg;
   logic [3:0]        pin_meta_reg;
   logic [3:0]        pin_sync_reg;
   logic              drop_a_clk_reg;
   logic              drop_a_dat_reg;
   logic              drop_b_clk_reg;
   logic              drop_b_dat_reg;
   tdil_port_vec_type tx_clk_reg;
   tdil_port_vec_type tx_dat_reg;

   tdil_port_vec_type port_loopback_cmd_seen;
   tdil_port_vec_type cmd_now;
   tdil_port_vec_type cmd_rise;
   tdil_port_vec_type drop_a_hit;
   tdil_port_vec_type drop_b_hit;
   tdil_port_vec_type insert_a_hit;
   tdil_port_vec_type insert_b_hit;

   tdil_sel_type      drop_a_selector;
   tdil_sel_type      drop_b_selector;
   tdil_sel_type      insert_a_selector;
   tdil_sel_type      insert_b_selector;

   logic              bus_req;
   logic              wr_lo;
   logic              wr_hi;
   logic [11:0]       adr_lb_low;
   logic [11:0]       adr_lb_high;
   logic [11:0]       adr_drop;
   logic [11:0]       adr_insert;
   logic [11:0]       adr_irq_stat;
   logic [11:0]       adr_irq_mask;
   logic              ins_a_clk;
   logic              ins_a_dat;
   logic              ins_b_clk;
   logic              ins_b_dat;
   logic              lb_event;

   // ----------------------------------------------------------------
   // Loopback command detection
   // ----------------------------------------------------------------
   // C3 carries the command when it is the inverse of both C1 and C2.
   genvar g;
   generate
      for (g = 0; g < `TDIL_PORT_COUNT; g = g + 1) begin : g_det
         assign cmd_now[g] = (t2_c3_i[g] != t2_c1_i[g]) && (t2_c3_i[g] != t2_c2_i[g]);
         tdil_lb_detect u_det (
            .clk_i     (clk_i),
            .rst_i     (rst_i),
            .frame_i   (t2_frame_i[g]),
            .cmd_now_i (cmd_now[g]),
            .seen_o    (port_loopback_cmd_seen[g]),
            .rise_o    (cmd_rise[g])
         );
      end
   endgenerate

   // ----------------------------------------------------------------
   // Selector fields
   // ----------------------------------------------------------------
   assign drop_a_selector   = drop_select_reg[`TDIL_SEL_A_LSB +: `TDIL_SEL_W];
   assign drop_b_selector   = drop_select_reg[`TDIL_SEL_B_LSB +: `TDIL_SEL_W];
   assign insert_a_selector = insert_select_reg[`TDIL_SEL_A_LSB +: `TDIL_SEL_W];
   assign insert_b_selector = insert_select_reg[`TDIL_SEL_B_LSB +: `TDIL_SEL_W];

   tdil_port_sel u_sel_drop_a (
      .sel_i (drop_a_selector),
      .hit_o (drop_a_hit)
   );

   tdil_port_sel u_sel_drop_b (
      .sel_i (drop_b_selector),
      .hit_o (drop_b_hit)
   );

   tdil_port_sel u_sel_ins_a (
      .sel_i (insert_a_selector),
      .hit_o (insert_a_hit)
   );

   tdil_port_sel u_sel_ins_b (
      .sel_i (insert_b_selector),
      .hit_o (insert_b_hit)
   );

   // ----------------------------------------------------------------
   // Insert pin synchronisers
   // ----------------------------------------------------------------
   // The insert pins run on the far equipment's clock, so each one
   // passes two flip-flops before any logic looks at it.
   always_ff @(posedge clk_i) begin
      if (rst_i) begin
         pin_meta_reg <= 4'h0;
         pin_sync_reg <= 4'h0;
      end else begin
         pin_meta_reg <= {insert_b_data_in_i, insert_b_clock_in_i,
                          insert_a_data_in_i, insert_a_clock_in_i};
         pin_sync_reg <= pin_meta_reg;
      end
   end

   assign ins_a_clk = pin_sync_reg[0];
   assign ins_a_dat = pin_sync_reg[1];
   assign ins_b_clk = pin_sync_reg[2];
   assign ins_b_dat = pin_sync_reg[3];

   // ----------------------------------------------------------------
   // Drop ports
   // ----------------------------------------------------------------
   // An empty one-hot vector gives zero, which holds the pins low.
   always_ff @(posedge clk_i) begin
      if (rst_i) begin
         drop_a_clk_reg <= 1'b0;
         drop_a_dat_reg <= 1'b0;
         drop_b_clk_reg <= 1'b0;
         drop_b_dat_reg <= 1'b0;
      end else begin
         drop_a_clk_reg <= |(drop_a_hit & lsp_rx_clk_i);
         drop_a_dat_reg <= |(drop_a_hit & lsp_rx_data_i);
         drop_b_clk_reg <= |(drop_b_hit & lsp_rx_clk_i);
         drop_b_dat_reg <= |(drop_b_hit & lsp_rx_data_i);
      end
   end

   // ----------------------------------------------------------------
   // Insert ports
   // ----------------------------------------------------------------
   // Port A wins if software breaks the one-port-one-insert rule; the
   // result is defined but the B stream is lost.
   generate
      for (g = 0; g < `TDIL_PORT_COUNT; g = g + 1) begin : g_ins
         always_ff @(posedge clk_i) begin
            if (rst_i) begin
               tx_clk_reg[g] <= 1'b0;
               tx_dat_reg[g] <= 1'b0;
            end else if (insert_a_hit[g]) begin
               tx_clk_reg[g] <= ins_a_clk;
               tx_dat_reg[g] <= ins_a_dat;
            end else if (insert_b_hit[g]) begin
               tx_clk_reg[g] <= ins_b_clk;
               tx_dat_reg[g] <= ins_b_dat;
            end else begin
               tx_clk_reg[g] <= lsp_tx_clk_i[g];
               tx_dat_reg[g] <= lsp_tx_data_i[g];
            end
         end
      end
   endgenerate

   // ----------------------------------------------------------------
   // Wishbone decode
   // ----------------------------------------------------------------
   assign adr_lb_low   = {`TDIL_IDX_LB_STATUS_LOW, 2'b00};
   assign adr_lb_high  = {`TDIL_IDX_LB_STATUS_HIGH, 2'b00};
   assign adr_drop     = {`TDIL_IDX_DROP_SELECT, 2'b00};
   assign adr_insert   = {`TDIL_IDX_INSERT_SELECT, 2'b00};
   assign adr_irq_stat = {`TDIL_IDX_IRQ_STATUS, 2'b00};
   assign adr_irq_mask = {`TDIL_IDX_IRQ_MASK, 2'b00};

   assign bus_req = wb_cyc_i && wb_stb_i && !ack_reg;
   assign wr_lo   = bus_req && wb_we_i && wb_sel_i[0];
   assign wr_hi   = bus_req && wb_we_i && wb_sel_i[1];

   always_ff @(posedge clk_i) begin
      if (rst_i) begin
         ack_reg <= 1'b0;
      end else begin
         ack_reg <= bus_req;
      end
   end

   // Unmapped words read as zero and swallow writes.
   always_ff @(posedge clk_i) begin
      if (rst_i) begin
         dat_reg <= 32'h0000_0000;
      end else if (bus_req && !wb_we_i) begin
         if (wb_adr_i == adr_lb_low) begin
            dat_reg <= {16'h0000, port_loopback_cmd_seen[`TDIL_LB_LOW_PORTS-1:0]};
         end else if (wb_adr_i == adr_lb_high) begin
            dat_reg <= {20'h00000, port_loopback_cmd_seen[`TDIL_PORT_COUNT-1:`TDIL_LB_LOW_PORTS]};
         end else if (wb_adr_i == adr_drop) begin
            dat_reg <= {16'h0000, drop_select_reg};
         end else if (wb_adr_i == adr_insert) begin
            dat_reg <= {16'h0000, insert_select_reg};
         end else if (wb_adr_i == adr_irq_stat) begin
            dat_reg <= {31'h0000_0000, irq_status_reg};
         end else if (wb_adr_i == adr_irq_mask) begin
            dat_reg <= {31'h0000_0000, irq_mask_reg};
         end else begin
            dat_reg <= 32'h0000_0000;
         end
      end
   end

   // ----------------------------------------------------------------
   // Select registers
   // ----------------------------------------------------------------
   // Bits 5 to 7 and 13 to 15 are not stored and read as zero.
   always_ff @(posedge clk_i) begin
      if (rst_i) begin
         drop_select_reg <= `TDIL_DROP_SELECT_RST;
      end else if (wb_adr_i == adr_drop) begin
         if (wr_lo) begin
            drop_select_reg[7:0] <= {3'h0, wb_dat_i[4:0]};
         end
         if (wr_hi) begin
            drop_select_reg[15:8] <= {3'h0, wb_dat_i[12:8]};
         end
      end
   end

   always_ff @(posedge clk_i) begin
      if (rst_i) begin
         insert_select_reg <= `TDIL_INSERT_SELECT_RST;
      end else if (wb_adr_i == adr_insert) begin
         if (wr_lo) begin
            insert_select_reg[7:0] <= {3'h0, wb_dat_i[4:0]};
         end
         if (wr_hi) begin
            insert_select_reg[15:8] <= {3'h0, wb_dat_i[12:8]};
         end
      end
   end

   // ----------------------------------------------------------------
   // Interrupt
   // ----------------------------------------------------------------
   assign lb_event = |cmd_rise;

   always_ff @(posedge clk_i) begin
      if (rst_i) begin
         irq_mask_reg <= `TDIL_IRQ_MASK_RST;
      end else if (wr_lo && wb_adr_i == adr_irq_mask) begin
         irq_mask_reg <= wb_dat_i[`TDIL_LB_IRQ_BIT];
      end
   end

   // A new event in the cycle of a clear write keeps the bit set.
   always_ff @(posedge clk_i) begin
      if (rst_i) begin
         irq_status_reg <= 1'b0;
      end else if (lb_event) begin
         irq_status_reg <= 1'b1;
      end else if (wr_lo && wb_adr_i == adr_irq_stat && wb_dat_i[`TDIL_LB_IRQ_BIT]) begin
         irq_status_reg <= 1'b0;
      end
   end

   always_ff @(posedge clk_i) begin
      if (rst_i) begin
         irq_reg <= 1'b0;
      end else begin
         irq_reg <= irq_status_reg && irq_mask_reg;
      end
   end

   // ----------------------------------------------------------------
   // Outputs
   // ----------------------------------------------------------------
   assign wb_ack_o           = ack_reg;
   assign wb_dat_o           = dat_reg;
   assign irq_o              = irq_reg;
   assign drop_a_clock_out_o = drop_a_clk_reg;
   assign drop_a_data_out_o  = drop_a_dat_reg;
   assign drop_b_clock_out_o = drop_b_clk_reg;
   assign drop_b_data_out_o  = drop_b_dat_reg;
   assign lsp_tx_clk_o       = tx_clk_reg;
   assign lsp_tx_data_o      = tx_dat_reg;

endmodule : tdil_top

// ==== test/tdil_far_end.sv ====
// Far-end T1/E1 equipment that drives the two insert ports.
module tdil_far_end (
   input  wire logic run_i,
   output logic      ins_a_clk_o,
   output logic      ins_a_dat_o,
   output logic      ins_b_clk_o,
   output logic      ins_b_dat_o
);
   timeunit 1ns;
   timeprecision 1ps;
   logic [7:0] pattern;
   // The line clock stands still low between bursts; data holds its last bit.
   initial begin
      pattern = 8'h1d;
      ins_a_clk_o = 1'b0;
      ins_a_dat_o = 1'b0;
      ins_b_clk_o = 1'b0;
      ins_b_dat_o = 1'b0;
      #21.3;
      forever begin
         if (run_i) begin
            ins_a_clk_o = 1'b1;
            ins_b_clk_o = 1'b1;
            #62.5;
            ins_a_clk_o = 1'b0;
            ins_b_clk_o = 1'b0;
            pattern = {pattern[6:0], pattern[7] ^ pattern[5]};
            ins_a_dat_o = pattern[0];
            ins_b_dat_o = pattern[3];
         end
         #62.5;
      end
   end
endmodule : tdil_far_end

// ==== test/tdil_top_props.sv ====
// Concurrent checks on the ports of the loopback status and drop and insert block.
module tdil_top_props
   import tdil_pkg::*;
(
   input wire logic                        clk_i,
   input wire logic                        rst_i,
   input wire logic                        wb_cyc_i,
   input wire logic                        wb_stb_i,
   input wire logic                        wb_we_i,
   input wire logic [11:0]                 wb_adr_i,
   input wire logic [3:0]                  wb_sel_i,
   input wire logic [31:0]                 wb_dat_i,
   input wire logic [31:0]                 wb_dat_o,
   input wire logic                        wb_ack_o,
   input wire logic                        irq_o,
   input wire tdil_pkg::tdil_port_vec_type lsp_rx_clk_i,
   input wire tdil_pkg::tdil_port_vec_type lsp_rx_data_i,
   input wire tdil_pkg::tdil_port_vec_type lsp_tx_data_i,
   input wire tdil_pkg::tdil_port_vec_type lsp_tx_data_o,
   input wire logic                        drop_a_clock_out_o,
   input wire logic                        drop_a_data_out_o,
   input wire logic                        drop_b_clock_out_o,
   input wire logic                        drop_b_data_out_o,
   input wire logic                        insert_a_data_in_i
);
   import tdil_pkg::*;
   // ----------------------------------------------------------------
   // Shadow of the select and mask registers
   // ----------------------------------------------------------------
   logic [4:0]        da_reg, db_reg, ia_reg, ib_reg;
   logic              mask_reg;
   logic              take, wr, ia_ok;
   logic [1:0]        exp_a, exp_b;
   tdil_port_vec_type keep;
   assign take = wb_cyc_i && wb_stb_i && !wb_ack_o;
   assign wr = take && wb_we_i;
   assign ia_ok = ia_reg >= 5'h01 && ia_reg <= 5'h1c;
   // Shadows move only at the take edge, as the design's registers do.
   always_ff @(posedge clk_i) begin
      if (rst_i) begin
         da_reg <= 5'h00;
         db_reg <= 5'h00;
         ia_reg <= 5'h00;
         ib_reg <= 5'h00;
         mask_reg <= 1'h0;
      end else if (wr) begin
         if (wb_adr_i == 12'h180 && wb_sel_i[0]) da_reg <= wb_dat_i[4:0];
         if (wb_adr_i == 12'h180 && wb_sel_i[1]) db_reg <= wb_dat_i[12:8];
         if (wb_adr_i == 12'h188 && wb_sel_i[0]) ia_reg <= wb_dat_i[4:0];
         if (wb_adr_i == 12'h188 && wb_sel_i[1]) ib_reg <= wb_dat_i[12:8];
         if (wb_adr_i == 12'h198 && wb_sel_i[0]) mask_reg <= wb_dat_i[0];
      end
   end
   always_comb begin
      exp_a = 2'h0;
      exp_b = 2'h0;
      if (da_reg >= 5'h01 && da_reg <= 5'h1c) exp_a = {lsp_rx_clk_i[da_reg-5'h01], lsp_rx_data_i[da_reg-5'h01]};
      if (db_reg >= 5'h01 && db_reg <= 5'h1c) exp_b = {lsp_rx_clk_i[db_reg-5'h01], lsp_rx_data_i[db_reg-5'h01]};
      for (int p = 0; p < 28; p++) begin
         keep[p] = !(ia_reg == 5'(p + 1) || ib_reg == 5'(p + 1));
      end
   end
   // ----------------------------------------------------------------
   // Assertions
   // ----------------------------------------------------------------
   default clocking @(posedge clk_i); endclocking
   default disable iff (rst_i);
   a_ack_pulse: assert property (wb_ack_o |=> !wb_ack_o)
      else $error("ack held longer than one cycle");
   a_ack_answer: assert property (take |=> wb_ack_o)
      else $error("request not answered in one cycle");
   a_upper_zero: assert property (wb_ack_o |-> wb_dat_o[31:16] == 16'h0000)
      else $error("upper read data not zero");
   a_drop_readback: assert property (
      take && !wb_we_i && wb_adr_i == 12'h180 |=> wb_dat_o[15:0] == {3'h0, db_reg, 3'h0, da_reg})
      else $error("drop select read back wrong");
   a_drop_a_route: assert property (1'b1 |=> {drop_a_clock_out_o, drop_a_data_out_o} == $past(exp_a))
      else $error("drop port a shows wrong port");
   a_drop_b_route: assert property (1'b1 |=> {drop_b_clock_out_o, drop_b_data_out_o} == $past(exp_b))
      else $error("drop port b shows wrong port");
   a_tx_keep: assert property (
      1'b1 |=> ((lsp_tx_data_o ^ $past(lsp_tx_data_i)) & $past(keep)) == 28'h0000000)
      else $error("unselected transmit port altered");
   a_insert_a: assert property (
      ia_ok && $past(ia_reg) == ia_reg && $past(ia_reg, 2) == ia_reg
      |-> lsp_tx_data_o[ia_reg-5'h01] == $past(insert_a_data_in_i, 3))
      else $error("insert port a data not substituted");
   a_irq_mask: assert property (!mask_reg |=> !irq_o)
      else $error("interrupt raised while masked");
   a_irq_hold: assert property (irq_o && mask_reg && !$past(wr) |=> irq_o)
      else $error("interrupt dropped without a clear");
endmodule : tdil_top_props

bind tdil_top tdil_top_props i_tdil_top_props (
   .clk_i(clk_i), .rst_i(rst_i), .wb_cyc_i(wb_cyc_i), .wb_stb_i(wb_stb_i), .wb_we_i(wb_we_i),
   .wb_adr_i(wb_adr_i), .wb_sel_i(wb_sel_i), .wb_dat_i(wb_dat_i), .wb_dat_o(wb_dat_o),
   .wb_ack_o(wb_ack_o), .irq_o(irq_o), .lsp_rx_clk_i(lsp_rx_clk_i), .lsp_rx_data_i(lsp_rx_data_i),
   .lsp_tx_data_i(lsp_tx_data_i), .lsp_tx_data_o(lsp_tx_data_o),
   .drop_a_clock_out_o(drop_a_clock_out_o), .drop_a_data_out_o(drop_a_data_out_o),
   .drop_b_clock_out_o(drop_b_clock_out_o), .drop_b_data_out_o(drop_b_data_out_o),
   .insert_a_data_in_i(insert_a_data_in_i));

// ==== test/test_tdil_top.sv ====
// Self-checking bench of the loopback status and drop and insert block.
`define CHK(got, exp) begin check_count++; if ((got) !== (exp)) begin fail_count++; \
   $display("unexpected at %0t ns: got %0h expected %0h", $time, (got), (exp)); end end
module test_tdil_top;
   timeunit 1ns;
   timeprecision 1ps;
   import tdil_pkg::*;
   logic              clk_i = 1'b0, rst_i = 1'b1, wb_cyc_i = 1'b0, wb_stb_i = 1'b0, wb_we_i = 1'b0;
   logic [11:0]       wb_adr_i = 12'h000;
   logic [31:0]       wb_dat_i = 32'h0, wb_dat_o, rd;
   logic              wb_ack_o, irq_o, far_run = 1'b0, ia_c, ia_d, ib_c, ib_d;
   logic              da_c, da_d, db_c, db_d;
   tdil_port_vec_type fr = '0, c1 = '0, c2 = '0, c3 = '0, pat = 28'h5a3c96f;
   tdil_port_vec_type rx_c = '0, rx_d = '0, tx_c = '0, tx_d = '0, txo_c, txo_d;
   int                fail_count = 0, check_count = 0, cycles = 0, p;
   int                lb_port[4] = '{0, 15, 16, 27};
   always #4 clk_i = ~clk_i;
   tdil_top i_tdil_top (.clk_i(clk_i), .rst_i(rst_i), .wb_cyc_i(wb_cyc_i), .wb_stb_i(wb_stb_i),
      .wb_we_i(wb_we_i), .wb_adr_i(wb_adr_i), .wb_sel_i(4'hf), .wb_dat_i(wb_dat_i), .wb_dat_o(wb_dat_o),
      .wb_ack_o(wb_ack_o), .irq_o(irq_o), .t2_frame_i(fr), .t2_c1_i(c1), .t2_c2_i(c2), .t2_c3_i(c3),
      .lsp_rx_clk_i(rx_c), .lsp_rx_data_i(rx_d), .lsp_tx_clk_i(tx_c), .lsp_tx_data_i(tx_d),
      .lsp_tx_clk_o(txo_c), .lsp_tx_data_o(txo_d), .drop_a_clock_out_o(da_c), .drop_a_data_out_o(da_d),
      .drop_b_clock_out_o(db_c), .drop_b_data_out_o(db_d), .insert_a_clock_in_i(ia_c),
      .insert_a_data_in_i(ia_d), .insert_b_clock_in_i(ib_c), .insert_b_data_in_i(ib_d));
   tdil_far_end i_tdil_far_end (.run_i(far_run), .ins_a_clk_o(ia_c), .ins_a_dat_o(ia_d),
      .ins_b_clk_o(ib_c), .ins_b_dat_o(ib_d));
   // ----------------------------------------------------------------
   // Closing report and hang guard
   // ----------------------------------------------------------------
   task automatic test_done;
      $display("Comparisons %0d, mismatches %0d", check_count, fail_count);
      if (fail_count == 0 && check_count > 0) begin
         $display("Regression OK");
      end else begin
         $display("Regression broken");
      end
      $finish;
   endtask : test_done
   always @(posedge clk_i) begin
      cycles++;
      if (cycles == 20000) begin
         fail_count++;
         test_done();
      end
   end
   // ----------------------------------------------------------------
   // Bus and stimulus tasks
   // ----------------------------------------------------------------
   task automatic wb(input logic we, input logic [11:0] adr, input logic [31:0] dat);
      @(posedge clk_i);
      {wb_cyc_i, wb_stb_i, wb_we_i, wb_adr_i, wb_dat_i} <= {2'b11, we, adr, dat};
      do @(posedge clk_i); while (wb_ack_o !== 1'b1);
      rd = wb_dat_o;
      {wb_cyc_i, wb_stb_i, wb_we_i} <= 3'b000;
   endtask : wb
   task automatic rd_chk(input logic [11:0] adr, input logic [31:0] exp);
      wb(1'b0, adr, 32'h0);
      `CHK(rd, exp)
   endtask : rd_chk
   task automatic lb_chk(input tdil_port_vec_type v);
      rd_chk(12'h170, {16'h0, v[15:0]});
      rd_chk(12'h178, {20'h0, v[27:16]});
   endtask : lb_chk
   task automatic frames(input int q, input logic cmd, input int n);
      for (int i = 0; i < n; i++) begin
         @(posedge clk_i);
         fr[q] <= 1'b1;
         c1[q] <= i[0];
         c2[q] <= i[0];
         c3[q] <= i[0] ^ cmd;
         @(posedge clk_i);
         fr[q] <= 1'b0;
      end
   endtask : frames
   function automatic logic [1:0] pick(input tdil_port_vec_type v, input int code);
      return (code >= 1 && code <= 28) ? {v[code-1], ~v[code-1]} : 2'b00;
   endfunction : pick
   // ----------------------------------------------------------------
   // Tests
   // ----------------------------------------------------------------
   initial begin
      repeat (10) @(posedge clk_i);
      rst_i <= 1'b0;
      foreach (lb_port[k]) rd_chk(12'h170 + 12'(k * 8), 32'h0);
      rd_chk(12'h198, 32'h0);
      wb(1'b1, 12'h180, 32'hffffffff);
      rd_chk(12'h180, 32'h00001f1f);
      wb(1'b1, 12'h188, 32'h0000e0e0);
      rd_chk(12'h188, 32'h0);
      wb(1'b1, 12'h1a0, 32'hffffffff);
      rd_chk(12'h1a0, 32'h0);
      $display("Test registers done");
      // Status is only meaningful in the T3 setting this bench models.
      foreach (lb_port[k]) begin
         p = lb_port[k];
         frames(p, 1'b1, 3);
         frames(p, 1'b0, 1);
         frames(p, 1'b1, 4);
         lb_chk('0);
         frames(p, 1'b1, 1);
         lb_chk(28'h1 << p);
         wb(1'b1, 12'h170 + 12'(p / 16 * 8), 32'h0);
         lb_chk(28'h1 << p);
         frames(p, 1'b0, 4);
         frames(p, 1'b1, 1);
         frames(p, 1'b0, 4);
         lb_chk(28'h1 << p);
         frames(p, 1'b0, 1);
         lb_chk('0);
      end
      $display("Test loopback status done");
      `CHK(irq_o, 1'b0)
      rd_chk(12'h190, 32'h1);
      wb(1'b1, 12'h198, 32'h1);
      repeat (2) @(posedge clk_i);
      `CHK(irq_o, 1'b1)
      wb(1'b1, 12'h190, 32'h1);
      repeat (2) @(posedge clk_i);
      `CHK(irq_o, 1'b0)
      frames(5, 1'b1, 5);
      repeat (3) @(posedge clk_i);
      `CHK(irq_o, 1'b1)
      wb(1'b1, 12'h190, 32'h1);
      frames(5, 1'b0, 5);
      repeat (3) @(posedge clk_i);
      `CHK(irq_o, 1'b0)
      wb(1'b1, 12'h198, 32'h0);
      $display("Test interrupt done");
      for (int c = 0; c < 32; c++) begin
         pat = {pat[26:0], pat[27]};
         rx_c <= pat;
         rx_d <= ~pat;
         wb(1'b1, 12'h180, {19'h0, 5'(31 - c), 3'h0, 5'(c)});
         repeat (2) @(posedge clk_i);
         `CHK({da_c, da_d, db_c, db_d}, {pick(pat, c), pick(pat, 31 - c)})
      end
      $display("Test drop select done");
      // Each insert port names its own transmit port.
      wb(1'b1, 12'h188, {19'h0, 5'd20, 3'h0, 5'd5});
      tx_d <= 28'h0f0f0f0;
      tx_c <= 28'hfffffff;
      far_run <= 1'b1;
      repeat (200) @(posedge clk_i);
      far_run <= 1'b0;
      repeat (40) @(posedge clk_i);
      `CHK({txo_c[4], txo_d[4], txo_c[19], txo_d[19]}, {1'b0, ia_d, 1'b0, ib_d})
      `CHK(txo_d & 28'hff7ffef, tx_d & 28'hff7ffef)
      wb(1'b1, 12'h188, {19'h0, 5'd29, 3'h0, 5'd0});
      far_run <= 1'b1;
      repeat (100) @(posedge clk_i);
      `CHK({txo_c, txo_d}, {tx_c, tx_d})
      $display("Test insert select done");
      test_done();
   end
endmodule : test_tdil_top
